// ---- bench/audio_interface_irq_aggregator_test.sv ----
`timescale 1ns/1ps
`include "irq_agg_defs.svh"
module audio_interface_irq_aggregator_test;
  import irq_agg_pkg::*;
  // --------------------------------
  // Stimulus and wiring
  // --------------------------------
  localparam logic [31:0] HI = {16'h0, `OFS_HI_LATCH};
  localparam logic [31:0] LO = {16'h0, `OFS_LO_LATCH};
  localparam logic [31:0] PRI = {16'h0, `OFS_PRI_SEL};
  localparam logic [31:0] RISE = {16'h0, `OFS_RISE_EN};
  localparam logic [31:0] FALL = {16'h0, `OFS_FALL_EN};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] audioIrqSrc = 32'h0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  word_t hwdata = 32'h0;
  word_t hrdata;
  word_t q;
  logic hreadyout, hresp, irqHigh, irqLow, svcHi, svcLo;
  int err_total = 0;
  int n_checks = 0;

  always #25 ref_clk = ~ref_clk;

  audio_irq_aggregator u_audio_irq_aggregator (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .audioIrqSrc(audioIrqSrc),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irqHigh(irqHigh), .irqLow(irqLow)
  );

  core_irq_model u_core_irq_model (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .irqHigh(irqHigh),
    .irqLow(irqLow), .svcHi(svcHi), .svcLo(svcLo)
  );

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait; a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        close_out();
      end
      @(posedge ref_clk);
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input word_t a, input word_t d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : xfer

  task automatic wr(input word_t a, input word_t d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input word_t a, input word_t exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk

  // Lines and the sink's view, settled after a few edges
  task automatic irq(input logic [3:0] exp);
    wait_clk(2);
    chk({28'h0, irqHigh, irqLow, svcHi, svcLo}, {28'h0, exp});
  endtask : irq

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    wait_clk(4);
    chk({31'h0, hreadyout}, 32'h0);
    sys_rst <= 1'b0;
    wait_clk(2);
    chk({31'h0, hreadyout}, 32'h1);
    rd(HI, 32'h0);
    rd(LO, 32'h0);
    rd(PRI, 32'h0);
    rd(RISE, 32'h0);
    rd(FALL, 32'h0);
    rd(HI + 32'h20, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(PRI, 32'hffff0000);
    wr(RISE, 32'hffffffff);
    wr(FALL, 32'hffffffff);
    wr(HI, 32'hffffffff);
    rd(PRI, 32'hffff0000);
    rd(RISE, 32'hffffffff);
    rd(FALL, 32'hffffffff);
    rd(HI, 32'h0);
    // All sources rise at once, split by priority
    audioIrqSrc <= 32'hffffffff;
    wait_clk(8);
    irq(4'hf);
    rd(HI, 32'hffff0000);
    rd(LO, 32'h0000ffff);
    irq(4'h5);
    rd(LO, 32'h00000200);
    rd(HI, 32'h0);
    // Falls seen only outside the rise-only group
    audioIrqSrc <= 32'h0;
    wait_clk(8);
    rd(HI, 32'hffff0000);
    rd(LO, 32'h0000fc00);
    irq(4'h0);
    // Short pulse, one source enabled, rising only
    wr(PRI, 32'h0);
    wr(RISE, 32'h00100000);
    wr(FALL, 32'h0);
    audioIrqSrc <= 32'hffffffff;
    wait_clk(3);
    audioIrqSrc <= 32'h0;
    wait_clk(8);
    irq(4'h5);
    rd(HI, 32'h0);
    rd(LO, 32'h00100000);
    rd(LO, 32'h0);
    irq(4'h0);
    close_out();
  end
endmodule : audio_interface_irq_aggregator_test

// ---- bench/core_irq_model.sv ----
`timescale 1ns/1ps
// --------------------------------
// Core-side interrupt sink
// --------------------------------
module core_irq_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic irqHigh,
  input wire logic irqLow,
  output logic svcHi,
  output logic svcLo
);
  // Service request per level; one cycle late like a real sampler
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      svcHi <= 1'b0;
      svcLo <= 1'b0;
    end else begin
      svcHi <= irqHigh;
      svcLo <= irqLow;
    end
  end
endmodule : core_irq_model

// ---- hw/audio_irq_aggregator.sv ----
`timescale 1ns/1ps
`include "irq_agg_defs.svh"
module audio_irq_aggregator #(
  parameter int NSRC = `NUM_SOURCES,
  parameter logic [31:0] RISE_ONLY = `RISE_ONLY_MASK,
  parameter int GTN = `GTN_BIT
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [NSRC-1:0] audioIrqSrc,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire irq_agg_pkg::word_t hwdata,
  input wire logic hready,
  output logic hreadyout,
  output irq_agg_pkg::word_t hrdata,
  output logic hresp,
  output logic irqHigh,
  output logic irqLow
);
  import irq_agg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  word_t priSel_r;
  word_t riseEn_r;
  word_t fallEn_r;
  word_t hiLatch_r;
  word_t loLatch_r;
  word_t hiLatch_nxt;
  word_t loLatch_nxt;
  word_t rdData;
  logic wrPend_r;
  reg_sel_t wrSel_r;
  logic readyOut_r;
  logic respErr_r;
  word_t rdData_r;
  logic irqHigh_r;
  logic irqLow_r;

  logic [NSRC-1:0] srcLevel;
  logic [NSRC-1:0] risePulse;
  logic [NSRC-1:0] fallPulse;
  word_t lvlW;
  word_t riseW;
  word_t fallW;
  word_t srcEvt;
  word_t hiEvt;
  word_t loEvt;
  word_t keepMask;

  // ----------------------------------------------------------------
  // Source sensing
  // ----------------------------------------------------------------
  src_edge_sense #(
    .W(NSRC)
  ) u_sense (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .srcPin(audioIrqSrc),
    .srcLevel(srcLevel),
    .risePulse(risePulse),
    .fallPulse(fallPulse)
  );

  // One configuration bit per source in each register
  assign lvlW = 32'(srcLevel);
  assign riseW = 32'(risePulse);
  assign fallW = 32'(fallPulse);

  // Falling edges masked off for rise-only sources
  assign srcEvt = (riseW & riseEn_r) |
    (fallW & fallEn_r & ~RISE_ONLY);

  // Steer each event to one priority
  assign hiEvt = srcEvt & priSel_r;
  assign loEvt = srcEvt & ~priSel_r;

  // Threshold bit is level-like and not read-cleared
  assign keepMask = 32'h00000001 << GTN;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [31:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a[15:0])
        `OFS_HI_LATCH: s = SEL_HI;
        `OFS_PRI_SEL: s = SEL_PRI;
        `OFS_LO_LATCH: s = SEL_LO;
        `OFS_RISE_EN: s = SEL_RISE;
        `OFS_FALL_EN: s = SEL_FALL;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  // Read-clear latch update: a set in the clearing cycle wins
  function automatic word_t latch_next(input word_t cur, input word_t evt,
      input logic clr, input word_t lvl, input word_t keep);
    word_t kept;
    kept = clr ? (cur & keep) : cur;
    // Threshold bit falls away with its cause
    kept = kept & (~keep | lvl);
    return kept | evt;
  endfunction : latch_next

  logic addrAccept;
  reg_sel_t addrSel;
  logic rdHi;
  logic rdLo;

  assign addrAccept = hsel & hready & htrans[1];
  assign addrSel = decode(haddr);
  assign rdHi = addrAccept & ~hwrite & (addrSel == SEL_HI);
  assign rdLo = addrAccept & ~hwrite & (addrSel == SEL_LO);

  always_comb begin
    unique case (addrSel)
      SEL_HI: rdData = hiLatch_r;
      SEL_PRI: rdData = priSel_r;
      SEL_LO: rdData = loLatch_r;
      SEL_RISE: rdData = riseEn_r;
      SEL_FALL: rdData = fallEn_r;
      SEL_NONE: rdData = 32'h00000000;
    endcase
  end

  // Read clears at the address-phase edge; data already captured
  assign hiLatch_nxt = latch_next(hiLatch_r, hiEvt, rdHi, lvlW,
    keepMask);
  assign loLatch_nxt = latch_next(loLatch_r, loEvt, rdLo, lvlW,
    keepMask);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wrPend_r <= 1'b0;
      wrSel_r <= SEL_NONE;
      rdData_r <= 32'h00000000;
    end else begin
      wrPend_r <= addrAccept & hwrite;
      wrSel_r <= addrSel;
      rdData_r <= (addrAccept & ~hwrite) ? rdData : 32'h00000000;
    end
  end

  // Writes land at the end of the data phase; latches ignore them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      priSel_r <= `RST_PRI_SEL;
      riseEn_r <= `RST_RISE_EN;
      fallEn_r <= `RST_FALL_EN;
    end else if (wrPend_r) begin
      if (wrSel_r == SEL_PRI) priSel_r <= hwdata;
      if (wrSel_r == SEL_RISE) riseEn_r <= hwdata;
      if (wrSel_r == SEL_FALL) fallEn_r <= hwdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hiLatch_r <= `RST_LATCH;
      loLatch_r <= `RST_LATCH;
      irqHigh_r <= 1'b0;
      irqLow_r <= 1'b0;
    end else begin
      hiLatch_r <= hiLatch_nxt;
      loLatch_r <= loLatch_nxt;
      irqHigh_r <= |hiLatch_nxt;
      irqLow_r <= |loLatch_nxt;
    end
  end

  // Zero wait states: every transfer completes in one data phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      readyOut_r <= 1'b0;
      respErr_r <= 1'b0;
    end else begin
      readyOut_r <= 1'b1;
      respErr_r <= 1'b0;
    end
  end

  assign hreadyout = readyOut_r;
  assign hrdata = rdData_r;
  assign hresp = respErr_r;
  assign irqHigh = irqHigh_r;
  assign irqLow = irqLow_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hiSet;
    (hiEvt != 32'h00000000);
  endsequence

  sequence s_loSet;
    (loEvt != 32'h00000000);
  endsequence

  property p_hiOut;
    @(posedge ref_clk) disable iff (sys_rst)
    irqHigh == (hiLatch_r != 32'h00000000);
  endproperty
  a_hiOut: assert property (p_hiOut)
    else $error("high output disagrees with latch");

  property p_loOut;
    @(posedge ref_clk) disable iff (sys_rst)
    irqLow == (loLatch_r != 32'h00000000);
  endproperty
  a_loOut: assert property (p_loOut)
    else $error("low output disagrees with latch");

  property p_hiCapture;
    @(posedge ref_clk) disable iff (sys_rst)
    s_hiSet |=> ((hiLatch_r & $past(hiEvt)) == $past(hiEvt))
      ##0 irqHigh;
  endproperty
  a_hiCapture: assert property (p_hiCapture)
    else $error("high event not latched");

  property p_loCapture;
    @(posedge ref_clk) disable iff (sys_rst)
    s_loSet |=> ((loLatch_r & $past(loEvt)) == $past(loEvt))
      ##0 irqLow;
  endproperty
  a_loCapture: assert property (p_loCapture)
    else $error("low event not latched");

  property p_edgeSelect;
    @(posedge ref_clk) disable iff (sys_rst)
    ((fallW & fallEn_r & ~RISE_ONLY & priSel_r) != 32'h00000000)
      |=> irqHigh;
  endproperty
  a_edgeSelect: assert property (p_edgeSelect)
    else $error("enabled falling edge missed");

  property p_riseOnly;
    @(posedge ref_clk) disable iff (sys_rst)
    ((fallW & RISE_ONLY) != 32'h00000000) |=>
      ((((hiLatch_r & ~$past(hiLatch_r)) |
      (loLatch_r & ~$past(loLatch_r))) & $past(fallW) & RISE_ONLY)
      == 32'h00000000);
  endproperty
  a_riseOnly: assert property (p_riseOnly)
    else $error("rise-only source fired on falling edge");

  property p_readClear;
    @(posedge ref_clk) disable iff (sys_rst)
    rdHi |=> ((hiLatch_r & ~keepMask & ~$past(hiEvt)) == 32'h00000000);
  endproperty
  a_readClear: assert property (p_readClear)
    else $error("high latch not cleared by read");

  property p_gtnKept;
    @(posedge ref_clk) disable iff (sys_rst)
    (rdHi || rdLo) && hiLatch_r[GTN] && lvlW[GTN] |=> hiLatch_r[GTN];
  endproperty
  a_gtnKept: assert property (p_gtnKept)
    else $error("threshold bit cleared by read");

  property p_gtnDrop;
    @(posedge ref_clk) disable iff (sys_rst)
    loLatch_r[GTN] && !lvlW[GTN] && !loEvt[GTN] |=> !loLatch_r[GTN];
  endproperty
  a_gtnDrop: assert property (p_gtnDrop)
    else $error("threshold bit outlived its cause");

  property p_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
    !rdLo |=> ((loLatch_r & $past(loLatch_r) & ~keepMask)
      == ($past(loLatch_r) & ~keepMask));
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("latched bit lost without read");

  property p_priWrite;
    @(posedge ref_clk) disable iff (sys_rst)
    wrPend_r && (wrSel_r == SEL_PRI) |=> priSel_r == $past(hwdata);
  endproperty
  a_priWrite: assert property (p_priWrite)
    else $error("priority write not stored");

  property p_noSpurious;
    @(posedge ref_clk) disable iff (sys_rst)
    ((hiLatch_r & ~$past(hiLatch_r)) & ~$past(hiEvt)) == 32'h00000000;
  endproperty
  a_noSpurious: assert property (p_noSpurious)
    else $error("high bit set without event");

  property p_loNoSpurious;
    @(posedge ref_clk) disable iff (sys_rst)
    ((loLatch_r & ~$past(loLatch_r)) & ~$past(loEvt)) == 32'h00000000;
  endproperty
  a_loNoSpurious: assert property (p_loNoSpurious)
    else $error("low bit set without event");

endmodule : audio_irq_aggregator

// ---- hw/irq_agg_defs.svh ----
`ifndef IRQ_AGG_DEFS_SVH
`define IRQ_AGG_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_HI_LATCH 16'h2480
`define OFS_PRI_SEL 16'h2484
`define OFS_LO_LATCH 16'h2488
`define OFS_RISE_EN 16'h248c
`define OFS_FALL_EN 16'h2490

// ----------------------------------------------------------------
// Sizes, fields and reset values
// ----------------------------------------------------------------
`define NUM_SOURCES 32
`define RISE_ONLY_MASK 32'h000003ff
`define GTN_BIT 9
`define RST_PRI_SEL 32'h00000000
`define RST_RISE_EN 32'h00000000
`define RST_FALL_EN 32'h00000000
`define RST_LATCH 32'h00000000

`endif

// ---- hw/irq_agg_pkg.sv ----
package irq_agg_pkg;

  typedef logic [31:0] word_t;

  typedef enum {
    SEL_NONE,
    SEL_HI,
    SEL_PRI,
    SEL_LO,
    SEL_RISE,
    SEL_FALL
  } reg_sel_t;

endpackage : irq_agg_pkg

// ---- hw/src_edge_sense.sv ----
`timescale 1ns/1ps
module src_edge_sense #(
  parameter int W = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] srcPin,
  output logic [W-1:0] srcLevel,
  output logic [W-1:0] risePulse,
  output logic [W-1:0] fallPulse
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then one stage of history
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= srcPin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign srcLevel = sync_r;
  assign risePulse = sync_r & ~prev_r;
  assign fallPulse = ~sync_r & prev_r;

endmodule : src_edge_sense
